// ===== shared/idl_pkg.sv
/*
 * constants for the four-channel interval data logger: register offsets,
 * field layouts, encodings, limits and state codes.
 * assumes a 125 mhz system clock and a one-minute time-of-day tick from outside.
 */
package idl_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int CODE_W = 12;
	localparam logic [11:0] CODE_MAX = 12'hfef; // 4079
	localparam int NUM_CH = 4;
	localparam int HIST_DEPTH = 16;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00; // [1:0] channel select, w1 to [8] commit txn
	localparam logic [7:0] REG_WEIGHT  = 8'h04; // pulse_weight code, channels 1/2
	localparam logic [7:0] REG_IVAL    = 8'h08; // interval_length_value code
	localparam logic [7:0] REG_LAST    = 8'h0c; // last_interval_value, read only
	localparam logic [7:0] REG_FACTOR  = 8'h10; // computation factor, read only
	localparam logic [7:0] REG_HIST    = 8'h14; // history entry at browse pointer
	localparam logic [7:0] REG_BROWSE  = 8'h18; // w: [0] forward, [1] backward
	localparam logic [7:0] REG_MONTH   = 8'h1c; // month-end reading, channels 1/2
	localparam logic [7:0] REG_READING = 8'h20; // current scaled reading
	localparam logic [7:0] REG_STATUS  = 8'h24; // channel_fault_value

	localparam int CTRL_COMMIT_BIT = 8;
	localparam int BROWSE_FWD_BIT  = 0;
	localparam int BROWSE_BWD_BIT  = 1;

	// pulse_weight encodings: 100, 10, 1, 0.1, 0.01 pulses per m3
	typedef enum logic [2:0] {
		PW_100   = 3'h0,
		PW_10    = 3'h1,
		PW_1     = 3'h2,
		PW_0P1   = 3'h3,
		PW_0P01  = 3'h4
	} idl_weight_t;
	localparam logic [2:0] WEIGHT_RST = 3'h2;

	// interval_length_value encodings in minutes
	localparam logic [5:0] IVAL_RST = 6'h3c;

	// pressure limit step boundaries in bar, resolution shift 0..5
	localparam logic [7:0] PLIM_4   = 8'h04;
	localparam logic [7:0] PLIM_8   = 8'h08;
	localparam logic [7:0] PLIM_16  = 8'h10;
	localparam logic [7:0] PLIM_32  = 8'h20;
	localparam logic [7:0] PLIM_64  = 8'h40;
	// temperature offset: 0 c = 273.15 k, stored in 0.1 k steps
	localparam logic [11:0] KELVIN_OFS = 12'haab; // 2731

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_CLOSE   = 3'b010,
		ST_STORE   = 3'b100
	} idl_state_t;
endpackage

// ===== rtl/idl_logger.sv
/*
 * interval data logger top: samples the corrector's totalisers and measured
 * pressure/temperature, forms interval values for four channels and offers
 * them to the read-out side through a plain register port.
 * assumes all inputs except the async reset I_RST_N synchronous to I_CLK_SYS; I_MIN_TICK pulses once per
 * minute aligned to the time of day, I_HOUR_TICK with the minute tick at :00,
 * I_DAY_CHANGE_1ST pulses at the day change on the first of the month.
 */
// The address-and-strobe port and the address map were decided locally.
// Operation
// - volume taken from internal totaliser readings
// - readings scaled by corrector display factor
// - flow is end minus start reading
// - pulse weight set only via interface
// - new weight applies from next interval
// - new interval applies after full hour
// - analog means clamped to 0..4079
// - pressure step follows upper alarm limit
// - temperature stored in 0.1 k steps
// - computation factor derived, read only
// - channel pointer advances after each transaction
// - history browse wraps both directions
// - interval 5..60 min, per channel, aligned
// - month-end readings saved for channels 1,2
`timescale 1ns/1ps
module idl_logger
	import idl_pkg::*;
#(
	parameter int RD_W = 32,
	parameter int HD   = HIST_DEPTH
) (
	input  wire logic               I_CLK_SYS,
	input  wire logic               I_RST_N,
	input  wire logic [RD_W-1:0]    I_ACT_TOTAL,
	input  wire logic [RD_W-1:0]    I_STD_TOTAL,
	input  wire logic [3:0]         I_DISP_SHIFT,
	input  wire logic [15:0]        I_PRESS_MBAR,
	input  wire logic [15:0]        I_TEMP_DK,
	input  wire logic [7:0]         I_PRESS_LIMIT_BAR,
	input  wire logic [3:0]         I_FAULT,
	input  wire logic               I_MIN_TICK,
	input  wire logic               I_HOUR_TICK,
	input  wire logic               I_DAY_CHANGE_1ST,
	input  wire logic [ADDR_W-1:0]  I_ADDR,
	input  wire logic [DATA_W-1:0]  I_WDATA,
	input  wire logic               I_WR,
	input  wire logic               I_RD,
	output logic      [DATA_W-1:0]  O_RDATA,
	output logic      [1:0]         O_ACTIVE_CH,
	output logic                    O_STORE_PULSE
);
	localparam int HP_W = $clog2(HD);

	// ==========================================================
	// state
	idl_state_t                  state_reg, state_next;
	logic [1:0]                  ch_reg, ch_next;
	logic [2:0]                  wpend_reg [2], wpend_next [2];
	logic [2:0]                  wact_reg [2], wact_next [2];
	logic [5:0]                  ipend_reg [NUM_CH], ipend_next [NUM_CH];
	logic [5:0]                  iact_reg [NUM_CH], iact_next [NUM_CH];
	logic [5:0]                  mcnt_reg [NUM_CH], mcnt_next [NUM_CH];
	logic [RD_W-1:0]             start_reg [2], start_next [2];
	logic [RD_W-1:0]             month_reg [2], month_next [2];
	logic [CODE_W+1:0]           cnt_reg [2], cnt_next [2];
	logic [27:0]                 asum_reg [2], asum_next [2];
	logic [15:0]                 an_reg [2], an_next [2];
	logic [CODE_W-1:0]           last_reg [NUM_CH], last_next [NUM_CH];
	logic [CODE_W-1:0]           hist_reg [NUM_CH][HD], hist_next [NUM_CH][HD];
	logic [HP_W-1:0]             wp_reg [NUM_CH], wp_next [NUM_CH];
	logic [HP_W-1:0]             bp_reg [NUM_CH], bp_next [NUM_CH];
	logic [3:0]                  fault_reg [NUM_CH], fault_next [NUM_CH];
	logic [NUM_CH-1:0]           due_reg, due_next;
	logic [DATA_W-1:0]           rdata_reg, rdata_next;

	// ==========================================================
	// combinational helpers
	logic [RD_W-1:0]   reading [2];
	logic [2:0]        pshift;
	logic [CODE_W-1:0] pcode, tcode;
	logic              txn;

	always_comb begin
		reading[0] = I_ACT_TOTAL >> I_DISP_SHIFT;
		reading[1] = I_STD_TOTAL >> I_DISP_SHIFT;
	end

	always_comb begin
		if (I_PRESS_LIMIT_BAR <= PLIM_4)
			pshift = 3'h0;
		else if (I_PRESS_LIMIT_BAR <= PLIM_8)
			pshift = 3'h1;
		else if (I_PRESS_LIMIT_BAR <= PLIM_16)
			pshift = 3'h2;
		else if (I_PRESS_LIMIT_BAR <= PLIM_32)
			pshift = 3'h3;
		else if (I_PRESS_LIMIT_BAR <= PLIM_64)
			pshift = 3'h4;
		else
			pshift = 3'h5;
	end

	function automatic logic [CODE_W-1:0] clamp16(input logic [15:0] v);
		if (v > 16'(CODE_MAX))
			return CODE_MAX;
		return v[CODE_W-1:0];
	endfunction

	function automatic logic [CODE_W+1:0] weigh(input logic [RD_W-1:0] d,
	                                             input logic [2:0] w);
		logic [RD_W+7:0] p;
		p = '0;
		unique case (w)
			PW_100:  p = {8'h00, d} * 40'd100;
			PW_10:   p = {8'h00, d} * 40'd10;
			PW_1:    p = {8'h00, d};
			PW_0P1:  p = {8'h00, d} / 40'd10;
			default: p = {8'h00, d} / 40'd100;
		endcase
		// saturation guards the short count against wrap
		if (p > 40'(CODE_MAX))
			return {2'b00, CODE_MAX};
		return p[CODE_W+1:0];
	endfunction

	// pressure code and kelvin tenths, derived from the current mean
	always_comb begin
		pcode = clamp16(an_reg[0] >> pshift);
		// offset add would wrap past 16 bits; saturate first
		tcode = (an_reg[1] > 16'hffff - 16'(KELVIN_OFS)) ? CODE_MAX
		        : clamp16(an_reg[1] + 16'(KELVIN_OFS));
	end

	assign txn = I_WR && I_ADDR == REG_CTRL && I_WDATA[CTRL_COMMIT_BIT];

	// ==========================================================
	// next state
	always_comb begin
		logic [CODE_W-1:0] val;
		val         = '0;
		state_next  = state_reg;
		ch_next     = ch_reg;
		wpend_next  = wpend_reg;
		wact_next   = wact_reg;
		ipend_next  = ipend_reg;
		iact_next   = iact_reg;
		mcnt_next   = mcnt_reg;
		start_next  = start_reg;
		month_next  = month_reg;
		cnt_next    = cnt_reg;
		asum_next   = asum_reg;
		an_next     = an_reg;
		last_next   = last_reg;
		hist_next   = hist_reg;
		wp_next     = wp_reg;
		bp_next     = bp_reg;
		due_next    = due_reg;
		rdata_next  = '0;
		for (int c = 0; c < NUM_CH; c++)
			fault_next[c] = fault_reg[c] | {3'h0, I_FAULT[c]};

		// weight and interval written only from the port
		if (I_WR) begin
			unique case (I_ADDR)
				REG_CTRL:   ch_next = I_WDATA[1:0];
				REG_WEIGHT: if (!ch_reg[1]) wpend_next[ch_reg[0]] = I_WDATA[2:0];
				REG_IVAL: begin
					// only divisors of the hour accepted
					if (I_WDATA[5:0] == 6'h05 || I_WDATA[5:0] == 6'h0a ||
					    I_WDATA[5:0] == 6'h0f || I_WDATA[5:0] == 6'h14 ||
					    I_WDATA[5:0] == 6'h1e || I_WDATA[5:0] == 6'h3c)
						ipend_next[ch_reg] = I_WDATA[5:0];
				end
				REG_BROWSE: begin
					if (I_WDATA[BROWSE_FWD_BIT])
						bp_next[ch_reg] = bp_reg[ch_reg] + 1'b1;
					else if (I_WDATA[BROWSE_BWD_BIT])
						bp_next[ch_reg] = bp_reg[ch_reg] - 1'b1;
				end
				default: ;
			endcase
		end
		if (I_RD) begin
			unique case (I_ADDR)
				REG_CTRL:    rdata_next = {30'h0, ch_reg};
				REG_WEIGHT:  rdata_next = ch_reg[1] ? '0 : {29'h0, wact_reg[ch_reg[0]]};
				REG_IVAL:    rdata_next = {26'h0, iact_reg[ch_reg]};
				REG_LAST:    rdata_next = {20'h0, last_reg[ch_reg]};
				REG_FACTOR:  rdata_next = {29'h0, pshift};
				REG_HIST:    rdata_next = {20'h0, hist_reg[ch_reg][bp_reg[ch_reg]]};
				REG_MONTH:   rdata_next = ch_reg[1] ? '0 : month_reg[ch_reg[0]];
				REG_READING: rdata_next = ch_reg[1] ? '0 : reading[ch_reg[0]];
				REG_STATUS:  rdata_next = {28'h0, fault_reg[ch_reg]};
				default:     rdata_next = '0;
			endcase
		end
		// advance after each transaction; host reselects
		if (txn) begin
			ch_next = ch_reg + 2'h1;
			// clear only faults no longer present; a live fault wins
			fault_next[ch_reg] = {3'h0, I_FAULT[ch_reg]};
		end

		if (I_DAY_CHANGE_1ST) begin
			month_next[0] = reading[0];
			month_next[1] = reading[1];
		end

		unique case (state_reg)
			ST_IDLE: begin
				// running analog sums, mean taken as the sum divided by 4096
				asum_next[0] = asum_reg[0] + 28'(I_PRESS_MBAR);
				asum_next[1] = asum_reg[1] + 28'(I_TEMP_DK);
				if (I_MIN_TICK) begin
					for (int c = 0; c < NUM_CH; c++) begin
						// boundary aligned to the time of day
						if (mcnt_reg[c] + 6'h1 >= iact_reg[c] || I_HOUR_TICK) begin
							mcnt_next[c] = '0;
							due_next[c]  = 1'b1;
						end else
							mcnt_next[c] = mcnt_reg[c] + 6'h1;
						// new interval only at the full hour
						if (I_HOUR_TICK)
							iact_next[c] = ipend_reg[c];
					end
					if (I_HOUR_TICK || mcnt_reg[0] + 6'h1 >= iact_reg[0] ||
					    mcnt_reg[1] + 6'h1 >= iact_reg[1] ||
					    mcnt_reg[2] + 6'h1 >= iact_reg[2] ||
					    mcnt_reg[3] + 6'h1 >= iact_reg[3])
						state_next = ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				for (int v = 0; v < 2; v++) begin
					// end minus start, weighted and saturated
					if (due_reg[v]) begin
						cnt_next[v]   = weigh(reading[v] - start_reg[v], wact_reg[v]);
						start_next[v] = reading[v];
						// new weight from the next interval on
						wact_next[v]  = wpend_reg[v];
					end
				end
				an_next[0] = asum_reg[0][27:12];
				an_next[1] = asum_reg[1][27:12];
				state_next = ST_STORE;
			end
			ST_STORE: begin
				for (int c = 0; c < NUM_CH; c++) begin
					if (due_reg[c]) begin
						val = (c < 2) ? cnt_next[c][CODE_W-1:0] : ((c == 2) ? pcode : tcode);
						if (c < 2)
							val = cnt_reg[c][CODE_W-1:0];
						last_next[c]             = val;
						hist_next[c][wp_reg[c]]  = val;
						wp_next[c]               = wp_reg[c] + 1'b1;
						bp_next[c]               = wp_reg[c];
					end
				end
				if (due_reg[2] || due_reg[3]) begin
					asum_next[0] = '0;
					asum_next[1] = '0;
				end
				due_next   = '0;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= ST_IDLE;
			ch_reg    <= '0;
			due_reg   <= '0;
			rdata_reg <= '0;
			for (int v = 0; v < 2; v++) begin
				wpend_reg[v] <= WEIGHT_RST;
				wact_reg[v]  <= WEIGHT_RST;
				start_reg[v] <= '0;
				month_reg[v] <= '0;
				cnt_reg[v]   <= '0;
				asum_reg[v]  <= '0;
				an_reg[v]    <= '0;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				ipend_reg[c] <= IVAL_RST;
				iact_reg[c]  <= IVAL_RST;
				mcnt_reg[c]  <= '0;
				last_reg[c]  <= '0;
				wp_reg[c]    <= '0;
				bp_reg[c]    <= '0;
				fault_reg[c] <= '0;
				for (int h = 0; h < HD; h++)
					hist_reg[c][h] <= '0;
			end
		end else begin
			state_reg <= state_next;
			ch_reg    <= ch_next;
			due_reg   <= due_next;
			rdata_reg <= rdata_next;
			wpend_reg <= wpend_next;
			wact_reg  <= wact_next;
			start_reg <= start_next;
			month_reg <= month_next;
			cnt_reg   <= cnt_next;
			asum_reg  <= asum_next;
			an_reg    <= an_next;
			ipend_reg <= ipend_next;
			iact_reg  <= iact_next;
			mcnt_reg  <= mcnt_next;
			last_reg  <= last_next;
			wp_reg    <= wp_next;
			bp_reg    <= bp_next;
			fault_reg <= fault_next;
			hist_reg  <= hist_next;
		end
	end

	assign O_RDATA       = rdata_reg;
	assign O_ACTIVE_CH   = ch_reg;
	assign O_STORE_PULSE = state_reg == ST_STORE;
endmodule

// ===== dv/idl_chk.sv
/* checker: port assertions for idl_logger.
   assumes one clock, async active-low reset, one-cycle bus strobes. */
`timescale 1ns/1ps
module idl_chk
	import idl_pkg::*;
(
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_RST_N,
	input  wire logic [7:0]        I_PRESS_LIMIT_BAR,
	input  wire logic              I_MIN_TICK,
	input  wire logic              I_HOUR_TICK,
	input  wire logic [ADDR_W-1:0] I_ADDR,
	input  wire logic [DATA_W-1:0] I_WDATA,
	input  wire logic              I_WR,
	input  wire logic              I_RD,
	input  wire logic [DATA_W-1:0] O_RDATA,
	input  wire logic [1:0]        O_ACTIVE_CH,
	input  wire logic              O_STORE_PULSE
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	// ==========
	// helpers
	function automatic logic [31:0] f_shift(input logic [7:0] l);
		f_shift = (l <= 8'h04) ? 32'h0 : (l <= 8'h08) ? 32'h1 : (l <= 8'h10) ? 32'h2 :
			(l <= 8'h20) ? 32'h3 : (l <= 8'h40) ? 32'h4 : 32'h5;
	endfunction
	sequence s_hour; I_MIN_TICK && I_HOUR_TICK; endsequence
	sequence s_store; !O_STORE_PULSE ##1 O_STORE_PULSE ##1 !O_STORE_PULSE; endsequence
	sequence s_commit; I_WR && I_ADDR == REG_CTRL && I_WDATA[8]; endsequence
	// ==========
	// assertions
	chk_hour_store: assert property (s_hour |-> ##1 s_store)
		else $error("no store two cycles after hour tick");
	chk_store_cause: assert property (O_STORE_PULSE |-> $past(I_MIN_TICK, 2))
		else $error("store without minute tick");
	chk_commit_adv: assert property (s_commit |=> O_ACTIVE_CH == $past(O_ACTIVE_CH) + 2'h1)
		else $error("channel did not advance");
	chk_select_ch: assert property (I_WR && I_ADDR == REG_CTRL && !I_WDATA[8]
		|=> O_ACTIVE_CH == $past(I_WDATA[1:0]))
		else $error("channel select lost");
	chk_ch_hold: assert property (!(I_WR && I_ADDR == REG_CTRL) |=> $stable(O_ACTIVE_CH))
		else $error("channel moved without access");
	chk_last_range: assert property (I_RD && I_ADDR == REG_LAST |=> O_RDATA <= 32'hfef)
		else $error("last value above range");
	chk_factor_val: assert property (I_RD && I_ADDR == REG_FACTOR && $stable(I_PRESS_LIMIT_BAR)
		|=> O_RDATA == f_shift($past(I_PRESS_LIMIT_BAR)))
		else $error("factor wrong for limit");
	chk_ival_legal: assert property (I_RD && I_ADDR == REG_IVAL
		|=> O_RDATA inside {32'h5, 32'ha, 32'hf, 32'h14, 32'h1e, 32'h3c})
		else $error("interval not legal");
	chk_rdata_idle: assert property (!I_RD |=> O_RDATA == 32'h0)
		else $error("read data outside read cycle");
endmodule
bind idl_logger idl_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
	.I_PRESS_LIMIT_BAR(I_PRESS_LIMIT_BAR), .I_MIN_TICK(I_MIN_TICK), .I_HOUR_TICK(I_HOUR_TICK),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.O_ACTIVE_CH(O_ACTIVE_CH), .O_STORE_PULSE(O_STORE_PULSE));

// ===== dv/idl_rdo.sv
/* read-out device model: register bus master.
   assumes strobes are sampled on the rising clock edge. */
`timescale 1ns/1ps
module idl_rdo
	import idl_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	output logic      [7:0]  o_addr,
	output logic      [31:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	initial begin
		o_addr = 8'h0;
		o_wdata = 32'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// released address shows inverse, not a stale value
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_clk);
		d = i_rdata;
	endtask
	task automatic sel(input int ch);
		wr(REG_CTRL, 32'(ch));
	endtask
	function automatic logic [31:0] pick_weight(input int q_centi, input int ival);
		int e;
		e = q_centi * ival / 60;
		pick_weight = (e <= 4079) ? 32'h0 : (e <= 40790) ? 32'h1 : (e <= 407900) ? 32'h2 :
			(e <= 4079000) ? 32'h3 : 32'h4;
	endfunction
endmodule

// ===== dv/testbench.sv
/* self-checking bench for idl_logger.
   assumes the read-out model drives the register bus. */
`timescale 1ns/1ps
module testbench
	import idl_pkg::*;
;
	logic        clk = 0, rst_n = 0, mtick = 0, htick = 0, dayc = 0;
	logic [31:0] act = 0, stdv = 0, rdata, r;
	logic [3:0]  shift = 0;
	logic [15:0] press = 0, temp = 0;
	logic [7:0]  plim = 8'h04, addr;
	logic [31:0] wdata;
	logic        wr, rd, stp;
	logic [1:0]  ach;
	integer      fails = 0, n_compared = 0, seed = 32'h1e42, cyc = 0, i, lastx, st0 = 0;
	integer      lims[11] = '{4, 5, 8, 9, 16, 17, 32, 33, 64, 65, 120};
	initial forever #4 clk = ~clk;
	idl_rdo rdo (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
		.o_rd(rd));
	idl_logger dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ACT_TOTAL(act), .I_STD_TOTAL(stdv),
		.I_DISP_SHIFT(shift), .I_PRESS_MBAR(press), .I_TEMP_DK(temp),
		.I_PRESS_LIMIT_BAR(plim), .I_FAULT(4'h0), .I_MIN_TICK(mtick), .I_HOUR_TICK(htick),
		.I_DAY_CHANGE_1ST(dayc), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .O_ACTIVE_CH(ach), .O_STORE_PULSE(stp));
	// ==========
	// model and checks
	task automatic print_verdict;
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input integer e);
		n_compared++;
		if (got !== e[31:0]) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	// weight code 2 is 1 per m3, 1 is 10, 0 is 100
	task automatic tick(input logic h, input integer mul);
		@(posedge clk);
		mtick <= 1'b1;
		htick <= h;
		@(posedge clk);
		mtick <= 1'b0;
		htick <= 1'b0;
		repeat (4) @(posedge clk);
		lastx = (act - st0) * mul;
		lastx = (lastx > 4079) ? 4079 : lastx;
		st0 = act;
	endtask
	task automatic rdch(input int ch, input logic [7:0] a, input integer e);
		rdo.sel(ch);
		rdo.rd(a, r);
		chk(r, e);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	// ==========
	// scenarios
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			if (i < 2) rdch(i, REG_WEIGHT, 2);
			rdch(i, REG_IVAL, 60);
			rdo.sel(i);
			rdo.wr(REG_CTRL, 32'h100);
			@(posedge clk);
			chk({30'h0, ach}, (i + 1) % 4);
		end
		for (i = 0; i < 11; i++) begin
			plim <= 8'(lims[i]);
			rdo.wr(REG_FACTOR, 32'h7);
			rdch(2, REG_FACTOR, (lims[i] <= 4) ? 0 : (lims[i] <= 8) ? 1 : (lims[i] <= 16) ? 2 :
				(lims[i] <= 32) ? 3 : (lims[i] <= 64) ? 4 : 5);
		end
		rdch(0, 8'h3c, 0);
		act <= $random(seed);
		stdv <= $random(seed);
		shift <= 4'h3;
		@(posedge clk);
		rdch(0, REG_READING, act >> 3);
		rdch(1, REG_READING, stdv >> 3);
		shift <= 4'h0;
		act <= act & 32'hffff;
		tick(1, 1);
		act <= act + ($random(seed) & 32'hfff);
		tick(1, 1);
		rdch(0, REG_LAST, lastx);
		act <= act + 5000;
		tick(1, 1);
		rdch(0, REG_LAST, 4079);
		rdo.sel(0);
		rdo.wr(REG_WEIGHT, rdo.pick_weight(30000, 60));
		rdch(0, REG_WEIGHT, 2);
		tick(1, 1);
		rdch(0, REG_WEIGHT, 1);
		act <= act + 300;
		tick(1, 10);
		rdch(0, REG_LAST, lastx);
		rdo.sel(2);
		rdo.wr(REG_IVAL, 32'h7);
		rdo.wr(REG_IVAL, 32'h5);
		rdch(2, REG_IVAL, 60);
		tick(0, 10);
		rdch(2, REG_IVAL, 60);
		tick(1, 10);
		rdch(2, REG_IVAL, 5);
		press <= 16'hffff;
		temp <= 16'hffff;
		plim <= 8'h04;
		tick(1, 10);
		// long enough for the mean to pass the storage range
		repeat (300) @(posedge clk);
		tick(1, 10);
		for (i = 2; i < 4; i++)
			rdch(i, REG_LAST, 4079);
		act <= $random(seed);
		@(posedge clk);
		dayc <= 1'b1;
		@(posedge clk);
		dayc <= 1'b0;
		repeat (2) @(posedge clk);
		rdch(0, REG_MONTH, act);
		// newest entry is 0, three stores back holds the 3000 count
		rdch(0, REG_HIST, 0);
		repeat (3) rdo.wr(REG_BROWSE, 32'h2);
		rdch(0, REG_HIST, 3000);
		repeat (16) rdo.wr(REG_BROWSE, 32'h1);
		rdch(0, REG_HIST, 3000);
		rdo.wr(REG_BROWSE, 32'h1);
		repeat (17) rdo.wr(REG_BROWSE, 32'h2);
		rdch(0, REG_HIST, 3000);
		print_verdict();
	end
endmodule
